// File: logic/bit_operand_addr.v
// Bit operand address former for carry instructions
`timescale 1ns/1ps
`include "status_flag_consts.vh"

module bit_operand_addr (
	input  wire [1:0]  i_mode,
	input  wire [11:0] i_direct_addr,
	input  wire [1:0]  i_direct_bit,
	input  wire [3:0]  i_l_reg,
	input  wire [3:0]  i_h_reg,
	input  wire [3:0]  i_offset,
	input  wire [7:0]  i_l_base,
	output reg  [11:0] o_addr,
	output reg  [1:0]  o_bit
);
	// L indirect: L[3:2] picks the word, L[1:0] the bit, from a 4-word base
	always @* begin
		case (i_mode)
		`AM_DIRECT: begin
			o_addr = i_direct_addr;
			o_bit  = i_direct_bit;
		end
		`AM_L_INDIRECT: begin
			o_addr = {4'hf, i_l_base[7:2], i_l_reg[3:2]};
			o_bit  = i_l_reg[1:0];
		end
		`AM_H_PLUS_DA: begin
			o_addr = {4'h0, i_h_reg, i_offset};
			o_bit  = i_direct_bit;
		end
		default: begin
			o_addr = i_direct_addr;
			o_bit  = i_direct_bit;
		end
		endcase
	end
endmodule // bit_operand_addr

// File: logic/status_flag_bank_logic.v
// Status-word flag bank: register bank enable, skip flags, carry, bank mapping
//
// How it works
// - Bank enable set: working register bank is select bits 1:0, banks 0 to 3.
// - Bank enable clear: working register bank is always bank 0.
// - Internal reset loads bank enable from bit 6 of program byte 0000H.
// - Vectored interrupt loads bank enable from vector entry bit 6 in the cycle the old one is pushed.
// - Bank enable pushed on interrupt entry, popped back to FB0H.0 on return.
// - Three skip flags follow execution, held at FB1H.0 to FB1H.2.
// - Skip flags readable only by 8-bit status read, never written directly.
// - Carry sits at FB1H.3, acting as arithmetic carry and Boolean accumulator.
// - Add/subtract with carry sets carry on overflow or borrow, else clears.
// - Reset during power-down keeps carry; so does any other reset, as reset never loads it.
// - Only listed instructions change carry; its bit writes spare other bits.
// - Set, clear and invert carry operations are provided.
// - Carry test skips the next instruction when carry is one.
// - Bit move copies carry to a memory bit or a memory bit to carry.
// - Rotate right through carry: bit 0 to carry, old carry to bit 3.
// - Bit AND, OR, XOR combine a memory bit with carry into carry.
// - Carry saved on interrupt entry and restored by interrupt return.
// - Bit operands: direct, L-register indirect, H base plus offset.
// - Memory bank enable clear: direct 80H and up to bank 15, else bank 0.
// - Register bank select is 4 bits, cleared by reset, saved with bank byte.
// - Status word reachable regardless of the memory bank enable value.
`timescale 1ns/1ps
`include "status_flag_consts.vh"

module status_flag_bank_logic (
	input  wire        i_sys_clk,
	input  wire        i_resetn,
	input  wire        i_power_down,
	input  wire [3:0]  i_op,
	input  wire        i_op_valid,
	input  wire [3:0]  i_alu_a,
	input  wire [3:0]  i_alu_b,
	input  wire        i_mem_bit,
	input  wire [1:0]  i_bit_mode,
	input  wire [11:0] i_bit_direct_addr,
	input  wire [1:0]  i_bit_direct_num,
	input  wire [3:0]  i_l_reg,
	input  wire [3:0]  i_h_reg,
	input  wire [3:0]  i_bit_offset,
	input  wire [7:0]  i_l_base,
	input  wire [7:0]  i_rom_data,
	input  wire        i_vector_valid,
	input  wire [2:0]  i_skip_next,
	input  wire        i_skip_update,
	input  wire [7:0]  i_pop_status,
	input  wire [7:0]  i_pop_bank_byte,
	input  wire        i_pop_bank_valid,
	input  wire        i_push_bank_req,
	input  wire [3:0]  i_reg_bank_sel_value,
	input  wire        i_reg_bank_sel_load,
	input  wire [3:0]  i_mem_bank_sel_value,
	input  wire        i_mem_bank_sel_load,
	input  wire [11:0] i_wr_addr,
	input  wire [1:0]  i_wr_bit,
	input  wire        i_wr_bit_data,
	input  wire        i_wr_bit_en,
	input  wire [7:0]  i_direct_addr,
	output reg  [11:0] o_rom_addr,
	output wire        o_rom_req,
	output reg  [1:0]  o_work_bank,
	output reg  [3:0]  o_alu_result,
	output reg  [3:0]  o_rot_result,
	output reg         o_skip_next_insn,
	output reg         o_mem_bit_we,
	output reg         o_mem_bit_data,
	output wire [11:0] o_mem_bit_addr,
	output wire [1:0]  o_mem_bit_num,
	output reg  [7:0]  o_push_status,
	output reg         o_push_valid,
	output reg  [7:0]  o_push_bank_byte,
	output wire [7:0]  o_status_word,
	output reg  [11:0] o_mapped_addr,
	output wire        o_register_bank_enable,
	output wire        o_memory_bank_enable
);
	reg        register_bank_enable_r;
	reg        memory_bank_enable_r;
	reg        carry_r;
	reg        carry_nxt;
	reg [2:0]  skip_flags_r;
	reg [1:0]  int_status_r;
	reg [3:0]  register_bank_select_r;
	reg [3:0]  memory_bank_select_r;
	reg [1:0]  state_r;
	reg [4:0]  sum;
	wire       exec;

	assign exec     = i_op_valid && (state_r == `ST_RUN);
	assign o_rom_req = (state_r == `ST_RESET_FETCH);

	////////////////////////////////////////////////////////////////////////
	// Operand address former
	bit_operand_addr u_bit_addr (
		.i_mode        (i_bit_mode),
		.i_direct_addr (i_bit_direct_addr),
		.i_direct_bit  (i_bit_direct_num),
		.i_l_reg       (i_l_reg),
		.i_h_reg       (i_h_reg),
		.i_offset      (i_bit_offset),
		.i_l_base      (i_l_base),
		.o_addr        (o_mem_bit_addr),
		.o_bit         (o_mem_bit_num)
	);

	////////////////////////////////////////////////////////////////////////
	// Status word view; an 8-bit read is the only path to the skip flags
	assign o_status_word = {int_status_r, memory_bank_enable_r, register_bank_enable_r,
		carry_r, skip_flags_r};
	assign o_register_bank_enable = register_bank_enable_r;
	assign o_memory_bank_enable   = memory_bank_enable_r;

	////////////////////////////////////////////////////////////////////////
	// Working bank and direct address mapping
	always @* begin
		if (register_bank_enable_r)
			o_work_bank = register_bank_select_r[1:0];
		else
			o_work_bank = 2'h0;
	end

	always @* begin
		if (memory_bank_enable_r)
			o_mapped_addr = {memory_bank_select_r, i_direct_addr};
		else if (i_direct_addr >= `DIRECT_HIGH_LIMIT)
			o_mapped_addr = {`BANK15_SEL, i_direct_addr};
		else
			o_mapped_addr = {`BANK0_SEL, i_direct_addr};
	end

	////////////////////////////////////////////////////////////////////////
	// Carry next value
	always @* begin
		carry_nxt = carry_r;
		sum       = 5'h00;
		if (i_op == `OP_ADC)
			sum = {1'b0, i_alu_a} + {1'b0, i_alu_b} + {4'h0, carry_r};
		else if (i_op == `OP_SUB_BORROW)
			sum = {1'b0, i_alu_a} - {1'b0, i_alu_b} - {4'h0, carry_r};
		if (exec) begin
			case (i_op)
			`OP_ADC, `OP_SUB_BORROW: carry_nxt = sum[4];
			`OP_SET_C:             carry_nxt = 1'b1;
			`OP_CLR_C:             carry_nxt = 1'b0;
			`OP_INV_C:             carry_nxt = ~carry_r;
			`OP_LD_C_FROM_BIT:     carry_nxt = i_mem_bit;
			`OP_ROT_RIGHT:         carry_nxt = i_alu_a[0];
			`OP_BIT_AND:           carry_nxt = carry_r & i_mem_bit;
			`OP_BIT_OR:            carry_nxt = carry_r | i_mem_bit;
			`OP_BIT_XOR:           carry_nxt = carry_r ^ i_mem_bit;
			`OP_INT_RETURN:        carry_nxt = i_pop_status[`SW_CARRY_BIT];
			default:               carry_nxt = carry_r;
			endcase
			// A 1-bit write to the carry position only touches carry
			if (i_wr_bit_en && i_wr_addr == `SW_HIGH_ADDR && i_wr_bit == 2'd3)
				carry_nxt = i_wr_bit_data;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Flag registers
	always @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			// Carry keeps its value: reset leaves it as it was
			register_bank_enable_r <= 1'b0;
			memory_bank_enable_r   <= 1'b0;
			skip_flags_r           <= 3'h0;
			int_status_r           <= 2'h0;
			register_bank_select_r <= `REG_BANK_SEL_RESET;
			memory_bank_select_r   <= `MEM_BANK_SEL_RESET;
			state_r                <= `ST_RESET_FETCH;
			o_rom_addr             <= `RESET_VEC_ADDR;
			o_alu_result           <= 4'h0;
			o_rot_result           <= 4'h0;
			o_skip_next_insn       <= 1'b0;
			o_mem_bit_we           <= 1'b0;
			o_mem_bit_data         <= 1'b0;
			o_push_status          <= 8'h00;
			o_push_valid           <= 1'b0;
			o_push_bank_byte       <= 8'h00;
		end else begin
			o_skip_next_insn <= 1'b0;
			o_mem_bit_we     <= 1'b0;
			o_push_valid     <= 1'b0;
			carry_r          <= carry_nxt;
			case (state_r)
			`ST_RESET_FETCH: begin
				// Strap-like load after reset release, from program byte 0000H
				register_bank_enable_r <= i_rom_data[`VEC_REG_BANK_EN_BIT];
				memory_bank_enable_r   <= i_rom_data[`VEC_MEM_BANK_EN_BIT];
				state_r <= i_power_down ? `ST_POWER_DOWN : `ST_RUN;
			end
			`ST_POWER_DOWN: begin
				if (!i_power_down)
					state_r <= `ST_RUN;
			end
			`ST_RUN: begin
				if (i_power_down)
					state_r <= `ST_POWER_DOWN;
			end
			default: state_r <= `ST_RUN;
			endcase
			if (exec) begin
				if (i_skip_update)
					skip_flags_r <= i_skip_next;
				o_alu_result <= sum[3:0];
				if (i_op == `OP_ROT_RIGHT)
					o_rot_result <= {carry_r, i_alu_a[3:1]};
				if (i_op == `OP_TEST_C)
					o_skip_next_insn <= carry_r;
				if (i_op == `OP_LD_BIT_FROM_C) begin
					o_mem_bit_we   <= 1'b1;
					o_mem_bit_data <= carry_r;
				end
				if (i_op == `OP_INT_ENTRY) begin
					o_push_status <= o_status_word;
					o_push_valid  <= 1'b1;
					o_push_bank_byte <= {memory_bank_select_r, register_bank_select_r};
					int_status_r  <= int_status_r + 2'h1;
					if (i_vector_valid) begin
						register_bank_enable_r <= i_rom_data[`VEC_REG_BANK_EN_BIT];
						memory_bank_enable_r   <= i_rom_data[`VEC_MEM_BANK_EN_BIT];
					end
				end else if (i_op == `OP_INT_RETURN) begin
					// The popped word is the 8-bit view: the low-address nibble sits on top
					register_bank_enable_r <= i_pop_status[`SW_REG_BANK_EN_BIT + 4];
					memory_bank_enable_r   <= i_pop_status[`SW_MEM_BANK_EN_BIT + 4];
					int_status_r           <= i_pop_status[7:6];
				end else if (i_wr_bit_en && i_wr_addr == `SW_LOW_ADDR) begin
					// Bit writes at the low word; skip flag positions never change here
					case (i_wr_bit)
					2'd0: register_bank_enable_r <= i_wr_bit_data;
					2'd1: memory_bank_enable_r   <= i_wr_bit_data;
					2'd2: int_status_r[0]        <= i_wr_bit_data;
					default: int_status_r[1]     <= i_wr_bit_data;
					endcase
				end
				if (i_push_bank_req)
					o_push_bank_byte <= {memory_bank_select_r, register_bank_select_r};
				if (i_pop_bank_valid) begin
					register_bank_select_r <= i_pop_bank_byte[3:0];
					memory_bank_select_r   <= i_pop_bank_byte[7:4];
				end else begin
					if (i_reg_bank_sel_load)
						register_bank_select_r <= i_reg_bank_sel_value;
					if (i_mem_bank_sel_load)
						memory_bank_select_r <= i_mem_bank_sel_value;
				end
			end
		end
	end
endmodule // status_flag_bank_logic

// File: logic/status_flag_consts.vh
// Constants for the status-word flag bank: offsets, bit positions, opcodes, states
`ifndef STATUS_FLAG_CONSTS_VH
`define STATUS_FLAG_CONSTS_VH

`define SW_LOW_ADDR        12'hfb0
`define SW_HIGH_ADDR       12'hfb1
`define SW_REG_BANK_EN_BIT 0
`define SW_MEM_BANK_EN_BIT 1
`define SW_CARRY_BIT       3
`define SW_SKIP_LOW_BIT    0
`define SW_SKIP_HIGH_BIT   2
`define VEC_REG_BANK_EN_BIT 6
`define VEC_MEM_BANK_EN_BIT 7
`define RESET_VEC_ADDR     12'h000
`define BANK15_SEL         4'hf
`define BANK0_SEL          4'h0
`define DIRECT_HIGH_LIMIT  8'h80
`define REG_BANK_SEL_RESET 4'h0
`define MEM_BANK_SEL_RESET 4'h0

`define OP_NONE            4'h0
`define OP_ADC             4'h1
`define OP_SUB_BORROW      4'h2
`define OP_SET_C           4'h3
`define OP_CLR_C           4'h4
`define OP_INV_C           4'h5
`define OP_TEST_C          4'h6
`define OP_LD_C_FROM_BIT   4'h7
`define OP_LD_BIT_FROM_C   4'h8
`define OP_ROT_RIGHT       4'h9
`define OP_BIT_AND         4'ha
`define OP_BIT_OR          4'hb
`define OP_BIT_XOR         4'hc
`define OP_INT_ENTRY       4'hd
`define OP_INT_RETURN      4'he

`define AM_DIRECT          2'h0
`define AM_L_INDIRECT      2'h1
`define AM_H_PLUS_DA       2'h2

`define ST_RUN             2'h0
`define ST_POWER_DOWN      2'h1
`define ST_RESET_FETCH     2'h2

`endif

// File: verification/status_flag_bank_props.sv
// Checker for the status-word flag bank
`timescale 1ns/1ps
`include "status_flag_consts.vh"

module status_flag_bank_props (
	input wire        i_sys_clk,
	input wire        i_resetn,
	input wire        i_power_down,
	input wire [3:0]  i_op,
	input wire        i_op_valid,
	input wire [3:0]  i_alu_a,
	input wire [3:0]  i_alu_b,
	input wire [7:0]  i_rom_data,
	input wire        i_vector_valid,
	input wire        i_skip_update,
	input wire [11:0] i_wr_addr,
	input wire [1:0]  i_wr_bit,
	input wire        i_wr_bit_en,
	input wire [7:0]  i_direct_addr,
	input wire        o_rom_req,
	input wire [1:0]  o_work_bank,
	input wire [3:0]  o_alu_result,
	input wire [3:0]  o_rot_result,
	input wire        o_skip_next_insn,
	input wire        o_mem_bit_we,
	input wire        o_mem_bit_data,
	input wire [7:0]  o_push_status,
	input wire        o_push_valid,
	input wire [7:0]  o_status_word,
	input wire [11:0] o_mapped_addr,
	input wire        o_register_bank_enable,
	input wire        o_memory_bank_enable
);
////////////////////////////////////////
// Only a level view of power-down: the bench keeps ops off the edge where it ends
wire ex = i_op_valid && !o_rom_req && !i_power_down;
wire c  = o_status_word[3];
default clocking @(posedge i_sys_clk); endclocking
default disable iff (!i_resetn);
////////////////////////////////////////
AST_BANK_OFF: assert property (!o_register_bank_enable |-> o_work_bank == 2'h0)
	else $error("work bank not zero");
AST_ENABLE_POS: assert property (o_status_word[5:4] == {o_memory_bank_enable, o_register_bank_enable})
	else $error("enable bits misplaced");
AST_RESET_LOAD: assert property ($rose(i_resetn) |=> o_register_bank_enable == $past(i_rom_data[6]))
	else $error("bank enable not loaded");
AST_SET_C: assert property (ex && i_op == `OP_SET_C |=> c)
	else $error("carry not set");
AST_INV_C: assert property (ex && i_op == `OP_INV_C |=> c != $past(c))
	else $error("carry not inverted");
AST_TEST_C: assert property (ex && i_op == `OP_TEST_C |=> o_skip_next_insn == $past(c))
	else $error("carry test wrong");
AST_ADC: assert property (ex && i_op == `OP_ADC |=> {c, o_alu_result} == $past(i_alu_a) + $past(i_alu_b) + $past(c))
	else $error("add with carry wrong");
AST_ROT: assert property (ex && i_op == `OP_ROT_RIGHT |=> c == $past(i_alu_a[0]) && o_rot_result == {$past(c), $past(i_alu_a[3:1])})
	else $error("rotate wrong");
AST_TO_BIT: assert property (ex && i_op == `OP_LD_BIT_FROM_C |=> o_mem_bit_we && o_mem_bit_data == $past(c))
	else $error("carry to bit wrong");
AST_SKIP_RO: assert property (ex && i_op == `OP_NONE && !i_skip_update && i_wr_bit_en && i_wr_addr == `SW_HIGH_ADDR && i_wr_bit != 2'h3 |=> $stable(o_status_word[2:0]))
	else $error("skip flags written");
AST_MAP: assert property (!o_memory_bank_enable |-> o_mapped_addr == {(i_direct_addr >= `DIRECT_HIGH_LIMIT) ? `BANK15_SEL : `BANK0_SEL, i_direct_addr})
	else $error("direct map wrong");
AST_INT: assert property (ex && i_op == `OP_INT_ENTRY && i_vector_valid |=> o_push_valid && o_push_status == $past(o_status_word) && o_register_bank_enable == $past(i_rom_data[6]))
	else $error("interrupt entry wrong");
COV_INT: cover property (ex && i_op == `OP_INT_ENTRY);
COV_SKIP: cover property (o_skip_next_insn);
COV_RST: cover property ($rose(i_resetn));
endmodule // status_flag_bank_props

bind status_flag_bank_logic status_flag_bank_props status_flag_bank_props_i (.*);

// File: verification/tb_status_flag_bank_logic.sv
// Self-checking bench for the status-word flag bank
`timescale 1ns/1ps
`include "status_flag_consts.vh"

module tb_status_flag_bank_logic;
logic        i_sys_clk = 0, i_resetn = 0, i_power_down = 0, i_op_valid = 0, i_mem_bit = 0;
logic        i_vector_valid = 0, i_skip_update = 0, i_pop_bank_valid = 0, i_push_bank_req = 0;
logic        i_reg_bank_sel_load = 0, i_mem_bank_sel_load = 0, i_wr_bit_data = 0, i_wr_bit_en = 0;
logic [1:0]  i_bit_mode = '0, i_bit_direct_num = '0, i_wr_bit = '0;
logic [2:0]  i_skip_next = '0;
logic [3:0]  i_op = '0, i_alu_a = '0, i_alu_b = '0, i_l_reg = '0, i_h_reg = '0, i_bit_offset = '0;
logic [3:0]  i_reg_bank_sel_value = '0, i_mem_bank_sel_value = '0;
logic [7:0]  i_l_base = '0, i_rom_data = '0, i_pop_status = '0, i_pop_bank_byte = '0, i_direct_addr = '0;
logic [11:0] i_bit_direct_addr = '0, i_wr_addr = '0;
logic [11:0] o_rom_addr, o_mem_bit_addr, o_mapped_addr;
logic [1:0]  o_work_bank, o_mem_bit_num;
logic [3:0]  o_alu_result, o_rot_result;
logic [7:0]  o_push_status, o_push_bank_byte, o_status_word;
logic        o_rom_req, o_skip_next_insn, o_mem_bit_we, o_mem_bit_data, o_push_valid;
logic        o_register_bank_enable, o_memory_bank_enable;
int          n_errors = 0, cmp_count = 0;
logic [3:0]  ta [6] = '{4'hf, 4'h7, 4'h3, 4'h3, 4'h5, 4'h0};
logic [3:0]  tb_b [6] = '{4'h1, 4'h8, 4'h4, 4'h4, 4'h2, 4'h0};

status_flag_bank_logic status_flag_bank_logic_i (.*);
always #25 i_sys_clk = ~i_sys_clk;
////////////////////////////////////////
task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
	cmp_count++;
	if (got !== exp) begin
		n_errors++;
		$display("BAD %s expected %h seen %h", nm, exp, got);
	end
endtask
// Strobes drop on the taking edge so no op runs twice and none is set twice in one step
task op(input logic [3:0] code);
	i_op = code;
	i_op_valid = 1'b1;
	@(posedge i_sys_clk);
	{i_op_valid, i_wr_bit_en, i_reg_bank_sel_load, i_mem_bank_sel_load} <= '0;
	{i_skip_update, i_push_bank_req, i_pop_bank_valid, i_vector_valid} <= '0;
	#1;
endtask
task cstep(input logic [3:0] code, input logic exp);
	op(code);
	chk("carry", exp, o_status_word[3]);
endtask
task wbit(input logic [11:0] a, input logic [1:0] b, input logic d);
	{i_wr_addr, i_wr_bit, i_wr_bit_data, i_wr_bit_en} = {a, b, d, 1'b1};
	op(`OP_NONE);
endtask
task do_reset(input logic [7:0] rom);
	i_rom_data = rom;
	i_resetn = 1'b0;
	repeat (2) @(posedge i_sys_clk);
	#1 i_resetn = 1'b1;
	@(posedge i_sys_clk);
	#1 chk("bank_en", rom[6], o_register_bank_enable);
	chk("rom_addr", 12'h000, o_rom_addr);
	chk("rom_req", 12'h0, o_rom_req);
	chk("skip", 12'h0, o_status_word[2:0]);
endtask
////////////////////////////////////////
task t_bank;
	for (int v = 0; v < 4; v++) begin
		i_reg_bank_sel_value = v[3:0];
		i_reg_bank_sel_load = 1'b1;
		op(`OP_NONE);
		chk("bank_on", v[11:0], o_work_bank);
	end
	wbit(`SW_LOW_ADDR, 2'h0, 1'b0);
	chk("bank_off", 12'h0, o_work_bank);
endtask
task t_carry;
	cstep(`OP_SET_C, 1'b1);
	cstep(`OP_INV_C, 1'b0);
	cstep(`OP_INV_C, 1'b1);
	cstep(`OP_CLR_C, 1'b0);
	wbit(`SW_HIGH_ADDR, 2'h3, 1'b1);
	chk("carry_wr", 12'h1, o_status_word[3]);
	op(`OP_TEST_C);
	chk("skip1", 12'h1, o_skip_next_insn);
	cstep(`OP_CLR_C, 1'b0);
	op(`OP_TEST_C);
	chk("skip0", 12'h0, o_skip_next_insn);
endtask
task t_alu;
	logic [4:0] exp;
	for (int i = 0; i < 6; i++) begin
		op(i[0] ? `OP_SET_C : `OP_CLR_C);
		{i_alu_a, i_alu_b} = {ta[i], tb_b[i]};
		exp = (i > 2) ? {1'b0, ta[i]} - tb_b[i] - i[0] : ta[i] + tb_b[i] + i[0];
		op((i > 2) ? `OP_SUB_BORROW : `OP_ADC);
		chk("alu", exp, {o_status_word[3], o_alu_result});
	end
endtask
task t_bits;
	cstep(`OP_SET_C, 1'b1);
	i_alu_a = 4'h6;
	cstep(`OP_ROT_RIGHT, 1'b0);
	chk("rot", 12'hb, o_rot_result);
	i_mem_bit = 1'b1;
	cstep(`OP_LD_C_FROM_BIT, 1'b1);
	i_mem_bit = 1'b0;
	cstep(`OP_BIT_AND, 1'b0);
	i_mem_bit = 1'b1;
	cstep(`OP_BIT_OR, 1'b1);
	cstep(`OP_BIT_XOR, 1'b0);
	op(`OP_LD_BIT_FROM_C);
	chk("bit_out", 12'h2, {o_mem_bit_we, o_mem_bit_data});
endtask
task t_skip;
	i_skip_next = 3'h5;
	i_skip_update = 1'b1;
	op(`OP_NONE);
	chk("skip", 12'h5, o_status_word[2:0]);
	wbit(`SW_HIGH_ADDR, 2'h0, 1'b0);
	wbit(`SW_HIGH_ADDR, 2'h1, 1'b1);
	chk("skip_ro", 12'h5, o_status_word[2:0]);
endtask
task t_int;
	logic [7:0] saved;
	cstep(`OP_SET_C, 1'b1);
	saved = o_status_word;
	i_rom_data = 8'h80;
	i_vector_valid = 1'b1;
	op(`OP_INT_ENTRY);
	chk("push", {4'h1, saved}, {o_push_valid, o_push_status});
	chk("vec_bank_en", 12'h2, {o_memory_bank_enable, o_register_bank_enable});
	i_pop_status = saved;
	op(`OP_INT_RETURN);
	chk("pop", saved[7:3], o_status_word[7:3]);
endtask
task t_map;
	{i_mem_bank_sel_value, i_mem_bank_sel_load, i_direct_addr} = {4'hf, 1'b1, 8'h90};
	op(`OP_NONE);
	chk("map_hi", 12'hf90, o_mapped_addr);
	i_direct_addr = 8'h34;
	#1 chk("map_lo", 12'h034, o_mapped_addr);
	{i_reg_bank_sel_value, i_reg_bank_sel_load} = {4'h2, 1'b1};
	op(`OP_NONE);
	i_push_bank_req = 1'b1;
	op(`OP_NONE);
	chk("bank_byte", 12'hf2, o_push_bank_byte);
	{i_pop_bank_byte, i_pop_bank_valid} = {8'h13, 1'b1};
	op(`OP_NONE);
	i_push_bank_req = 1'b1;
	op(`OP_NONE);
	chk("bank_pop", 12'h13, o_push_bank_byte);
endtask
task t_addr;
	{i_bit_direct_addr, i_bit_direct_num, i_l_base, i_l_reg} = {12'hfb1, 2'h2, 8'hc4, 4'hd};
	{i_h_reg, i_bit_offset} = {4'h3, 4'hf};
	for (int m = 0; m < 3; m++) begin
		i_bit_mode = m[1:0];
		#1 chk("bit_addr", m == 0 ? 14'h3ec6 : m == 1 ? 14'h3f1d : 14'h00fe,
			{o_mem_bit_addr, o_mem_bit_num});
	end
endtask
task t_pd;
	cstep(`OP_SET_C, 1'b1);
	i_power_down = 1'b1;
	do_reset(8'h00);
	chk("pd_carry", 12'h1, o_status_word[3]);
	cstep(`OP_CLR_C, 1'b1);
	i_power_down = 1'b0;
	repeat (2) @(posedge i_sys_clk);
	#1 cstep(`OP_CLR_C, 1'b0);
endtask
////////////////////////////////////////
task finish_test;
	if (n_errors == 0 && cmp_count > 0) $display("All checks passed");
	else $display("Checks failed");
	$finish;
endtask
initial begin
	do_reset(8'h40);
	t_bank;
	t_carry;
	t_alu;
	t_bits;
	t_skip;
	t_int;
	t_map;
	t_addr;
	t_pd;
	finish_test;
end
// Whole run is about 54 cycles; this leaves ample margin
initial begin
	#100000;
	n_errors++;
	finish_test;
end
endmodule // tb_status_flag_bank_logic
